//--- src/overlay_word_gen.sv
`timescale 1ns/100ps
module overlay_word_gen #(
    parameter logic [15:0] MDMA   = 16'h0007,
    parameter logic [15:0] UDMA   = 16'h003F,
    parameter logic [63:0] MAXLBA = 64'h0000_0000_0950_F8AF,
    parameter logic [15:0] FEAT   = 16'h008F
) (
    input  wire logic [7:0]  word_idx,
    output logic      [15:0] word_data
);
    logic [15:0] words [0:7];
    logic [7:0]  byte_sum;
    logic [7:0]  checksum;

    assign words[0] = pq_dco_pkg::STRUCT_REV;
    assign words[1] = MDMA;
    assign words[2] = UDMA;
    assign words[3] = MAXLBA[15:0];
    assign words[4] = MAXLBA[31:16];
    assign words[5] = MAXLBA[47:32];
    assign words[6] = MAXLBA[63:48];
    assign words[7] = FEAT;

    // constant fold: words 8 through 254 are reserved zero
    always_comb begin
        byte_sum = pq_dco_pkg::SIGNATURE;
        for (int i = 0; i < 8; i++) begin
            byte_sum = 8'(byte_sum + words[i][7:0] + words[i][15:8]);
        end
        checksum = 8'(-byte_sum);
    end

    always_comb begin
        if (word_idx == pq_dco_pkg::WORD_LAST) begin
            word_data = {checksum, pq_dco_pkg::SIGNATURE};
        end else if (word_idx <= pq_dco_pkg::WORD_FEAT) begin
            word_data = words[word_idx[2:0]];
        end else begin
            word_data = 16'h0000;
        end
    end
endmodule

//--- src/power_query_and_config_overlay.sv
`timescale 1ns/100ps
module power_query_and_config_overlay #(
    parameter logic [15:0] FACT_MDMA     = 16'h0007,
    parameter logic [15:0] FACT_UDMA     = 16'h003F,
    parameter logic [63:0] FACT_MAXLBA   = 64'h0000_0000_0950_F8AF,
    parameter logic [15:0] FACT_FEAT     = 16'h008F,
    parameter bit          DCO_SUPPORTED = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        ata_reset,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  features,
    input  wire logic        spindle_at_speed,
    input  wire logic        standby_mode,
    input  wire logic        sleep_mode,
    input  wire logic        hpa_established,
    input  wire logic        max_addr_locked,
    input  wire logic        rd_ready,
    input  wire logic        wr_valid,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic      [7:0]  sector_count,
    output logic      [7:0]  lba_mid,
    output logic      [7:0]  lba_high,
    output logic      [7:0]  error_reg,
    output logic      [7:0]  status_reg,
    output logic             cmd_done,
    output logic             frozen,
    output logic      [15:0] cap_mdma,
    output logic      [15:0] cap_udma,
    output logic      [63:0] cap_max_lba,
    output logic      [15:0] cap_feat
);
    pq_dco_pkg::phase_e phase;
    logic [7:0]  idx;
    logic [7:0]  gen_idx;
    logic [15:0] gen_word;
    logic [15:0] rx_mdma;
    logic [15:0] rx_udma;
    logic [63:0] rx_lba;
    logic [15:0] rx_feat;
    logic [7:0]  rx_sum;
    logic        rx_sig_ok;

    logic        is_pq;
    logic        is_dco;
    logic        sub_valid;
    logic        fin;
    logic        fin_abort;
    logic [7:0]  fin_sc;
    logic [7:0]  fin_word;
    logic        do_restore;
    logic        do_freeze;
    logic        do_set;
    logic        start_send;
    logic        start_recv;
    logic        lba_change;

    assign is_pq  = cmd_wr && !ata_reset && phase == pq_dco_pkg::IDLE &&
                    (cmd_code == pq_dco_pkg::OP_POWER_QUERY ||
                     cmd_code == pq_dco_pkg::OP_POWER_QUERY_ALT);
    assign is_dco = cmd_wr && !ata_reset && phase == pq_dco_pkg::IDLE &&
                    cmd_code == pq_dco_pkg::OP_OVERLAY;
    assign sub_valid = features == pq_dco_pkg::SUB_RESTORE || features == pq_dco_pkg::SUB_FREEZE ||
                       features == pq_dco_pkg::SUB_IDENTIFY || features == pq_dco_pkg::SUB_SET;
    assign lba_change = rx_lba != cap_max_lba;

    overlay_word_gen #(
        .MDMA   (FACT_MDMA),
        .UDMA   (FACT_UDMA),
        .MAXLBA (FACT_MAXLBA),
        .FEAT   (FACT_FEAT)
    ) u_gen (
        .word_idx  (gen_idx),
        .word_data (gen_word)
    );
    // identify always serves the full capability set, never the reduced one
    assign gen_idx = (phase == pq_dco_pkg::IDLE) ? pq_dco_pkg::WORD_REV : 8'(idx + 8'h01);

    // completion decision; checks are ordered by priority of the reason code
    always_comb begin
        fin        = 1'b0;
        fin_abort  = 1'b0;
        fin_sc     = pq_dco_pkg::RSN_NONE;
        fin_word   = pq_dco_pkg::BIT_ZERO;
        do_restore = 1'b0;
        do_freeze  = 1'b0;
        do_set     = 1'b0;
        start_send = 1'b0;
        start_recv = 1'b0;
        case (phase)
            pq_dco_pkg::IDLE: begin
                if (is_pq) begin
                    fin    = 1'b1;
                    fin_sc = (spindle_at_speed && !standby_mode && !sleep_mode) ?
                             pq_dco_pkg::SC_SPUN_UP : pq_dco_pkg::SC_NOT_READY;
                end else if (is_dco) begin
                    if (!DCO_SUPPORTED) begin
                        fin = 1'b1; fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_UNSUPPORTED;
                    end else if (!sub_valid) begin
                        fin = 1'b1; fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_BAD_SUB;
                    end else if (frozen) begin
                        fin = 1'b1; fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_FROZEN;
                    end else if (features == pq_dco_pkg::SUB_RESTORE) begin
                        fin = 1'b1;
                        if (cap_max_lba != FACT_MAXLBA && max_addr_locked) begin
                            fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_MAX_LOCKED;
                            fin_word  = pq_dco_pkg::WORD_LBA0;
                        end else if (cap_max_lba != FACT_MAXLBA && hpa_established) begin
                            fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_HPA;
                            fin_word  = pq_dco_pkg::WORD_LBA0;
                        end else begin
                            do_restore = 1'b1;
                        end
                    end else if (features == pq_dco_pkg::SUB_FREEZE) begin
                        fin = 1'b1; do_freeze = 1'b1;
                    end else if (features == pq_dco_pkg::SUB_IDENTIFY) begin
                        start_send = 1'b1;
                    end else begin
                        start_recv = 1'b1;
                    end
                end
            end
            pq_dco_pkg::SEND: begin
                fin = rd_valid && rd_ready && idx == pq_dco_pkg::WORD_LAST;
            end
            pq_dco_pkg::RECV: begin
                fin = 1'b0;
            end
            pq_dco_pkg::APPLY: begin
                fin = 1'b1;
                if (rx_sum != 8'h00 || !rx_sig_ok) begin
                    fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_OTHER;
                    fin_word  = pq_dco_pkg::WORD_LAST;
                end else if (lba_change && max_addr_locked) begin
                    fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_MAX_LOCKED;
                    fin_word  = pq_dco_pkg::WORD_LBA0;
                end else if (lba_change && hpa_established) begin
                    fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_HPA;
                    fin_word  = pq_dco_pkg::WORD_LBA0;
                end else if (rx_lba > FACT_MAXLBA) begin
                    fin_abort = 1'b1; fin_sc = pq_dco_pkg::RSN_OTHER;
                    fin_word  = pq_dco_pkg::WORD_LBA0;
                end else begin
                    // a reset landing here drops the whole set, caps included
                    do_set = !ata_reset;
                end
            end
            default: begin
                fin = 1'b0;
            end
        endcase
    end

    // overlay state only falls to power-on reset, never to ata_reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frozen      <= 1'b0;
            cap_mdma    <= FACT_MDMA;
            cap_udma    <= FACT_UDMA;
            cap_max_lba <= FACT_MAXLBA;
            cap_feat    <= FACT_FEAT;
        end else begin
            if (do_freeze) begin
                frozen <= 1'b1;
            end
            if (do_restore) begin
                cap_mdma    <= FACT_MDMA;
                cap_udma    <= FACT_UDMA;
                cap_max_lba <= FACT_MAXLBA;
                cap_feat    <= FACT_FEAT;
            end else if (do_set) begin
                cap_mdma    <= rx_mdma & FACT_MDMA;
                cap_udma    <= rx_udma & FACT_UDMA;
                cap_max_lba <= rx_lba;
                cap_feat    <= rx_feat & FACT_FEAT;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase    <= pq_dco_pkg::IDLE;
            idx      <= 8'h00;
            rd_valid <= 1'b0;
            rd_data  <= 16'h0000;
        end else if (ata_reset) begin
            phase    <= pq_dco_pkg::IDLE;
            idx      <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            case (phase)
                pq_dco_pkg::IDLE: begin
                    idx <= 8'h00;
                    if (start_send) begin
                        phase    <= pq_dco_pkg::SEND;
                        rd_valid <= 1'b1;
                        rd_data  <= gen_word;
                    end else if (start_recv) begin
                        phase <= pq_dco_pkg::RECV;
                    end
                end
                pq_dco_pkg::SEND: begin
                    if (rd_valid && rd_ready) begin
                        idx <= 8'(idx + 8'h01);
                        if (idx == pq_dco_pkg::WORD_LAST) begin
                            phase    <= pq_dco_pkg::IDLE;
                            rd_valid <= 1'b0;
                        end else begin
                            rd_data <= gen_word;
                        end
                    end
                end
                pq_dco_pkg::RECV: begin
                    if (wr_valid) begin
                        idx <= 8'(idx + 8'h01);
                        if (idx == pq_dco_pkg::WORD_LAST) begin
                            phase <= pq_dco_pkg::APPLY;
                        end
                    end
                end
                pq_dco_pkg::APPLY: begin
                    phase <= pq_dco_pkg::IDLE;
                end
                default: begin
                    phase <= pq_dco_pkg::IDLE;
                end
            endcase
        end
    end

    // incoming overlay capture and running byte sum
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_mdma   <= 16'h0000;
            rx_udma   <= 16'h0000;
            rx_lba    <= 64'h0;
            rx_feat   <= 16'h0000;
            rx_sum    <= 8'h00;
            rx_sig_ok <= 1'b0;
        end else if (start_recv) begin
            rx_sum    <= 8'h00;
            rx_sig_ok <= 1'b0;
        end else if (phase == pq_dco_pkg::RECV && wr_valid) begin
            rx_sum <= 8'(rx_sum + wr_data[7:0] + wr_data[15:8]);
            case (idx)
                pq_dco_pkg::WORD_MDMA: rx_mdma        <= wr_data;
                pq_dco_pkg::WORD_UDMA: rx_udma        <= wr_data;
                pq_dco_pkg::WORD_LBA0: rx_lba[15:0]   <= wr_data;
                pq_dco_pkg::WORD_LBA1: rx_lba[31:16]  <= wr_data;
                pq_dco_pkg::WORD_LBA2: rx_lba[47:32]  <= wr_data;
                pq_dco_pkg::WORD_LBA3: rx_lba[63:48]  <= wr_data;
                pq_dco_pkg::WORD_FEAT: rx_feat        <= wr_data;
                pq_dco_pkg::WORD_LAST: rx_sig_ok      <= wr_data[7:0] == pq_dco_pkg::SIGNATURE;
                default:               rx_sum         <= 8'(rx_sum + wr_data[7:0] + wr_data[15:8]);
            endcase
        end
    end

    // task file answer; bit index is always zero since only whole-word checks exist
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sector_count <= pq_dco_pkg::REG_CLEAR;
            lba_mid      <= pq_dco_pkg::REG_CLEAR;
            lba_high     <= pq_dco_pkg::REG_CLEAR;
            error_reg    <= pq_dco_pkg::REG_CLEAR;
            status_reg   <= pq_dco_pkg::STATUS_READY;
            cmd_done     <= 1'b0;
        end else if (ata_reset) begin
            sector_count <= pq_dco_pkg::REG_CLEAR;
            lba_mid      <= pq_dco_pkg::REG_CLEAR;
            lba_high     <= pq_dco_pkg::REG_CLEAR;
            error_reg    <= pq_dco_pkg::REG_CLEAR;
            status_reg   <= pq_dco_pkg::STATUS_READY;
            cmd_done     <= 1'b0;
        end else begin
            cmd_done <= fin;
            if (fin) begin
                sector_count <= fin_sc;
                lba_high     <= fin_word;
                lba_mid      <= pq_dco_pkg::BIT_ZERO;
                error_reg    <= pq_dco_pkg::REG_CLEAR;
                error_reg[pq_dco_pkg::ERR_ABT] <= fin_abort;
                status_reg   <= pq_dco_pkg::STATUS_READY;
                status_reg[pq_dco_pkg::ST_ERR] <= fin_abort;
            end else if (start_send || start_recv) begin
                status_reg <= pq_dco_pkg::STATUS_READY;
                status_reg[pq_dco_pkg::ST_DRQ] <= 1'b1;
            end else if (phase == pq_dco_pkg::RECV && wr_valid && idx == pq_dco_pkg::WORD_LAST) begin
                status_reg <= pq_dco_pkg::REG_CLEAR;
                status_reg[pq_dco_pkg::ST_BSY] <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_pq_spun_up: assert property (is_pq && spindle_at_speed && !standby_mode && !sleep_mode |=>
        cmd_done && sector_count == pq_dco_pkg::SC_SPUN_UP && !error_reg[pq_dco_pkg::ERR_ABT])
        else $error("power query did not report spun up");
    chk_pq_alt_down: assert property (is_pq && cmd_code == pq_dco_pkg::OP_POWER_QUERY_ALT && sleep_mode |=>
        cmd_done && sector_count == pq_dco_pkg::SC_NOT_READY)
        else $error("alternate power query not answered zero");
    chk_frozen_abort: assert property (is_dco && sub_valid && frozen && DCO_SUPPORTED |=>
        error_reg[pq_dco_pkg::ERR_ABT] && sector_count == pq_dco_pkg::RSN_FROZEN && !rd_valid)
        else $error("frozen overlay command not aborted");
    chk_frozen_sticky: assert property (frozen |=> frozen)
        else $error("frozen state dropped without power-down");
    chk_bad_sub_abort: assert property (is_dco && !sub_valid && DCO_SUPPORTED |=>
        error_reg[pq_dco_pkg::ERR_ABT] && status_reg[pq_dco_pkg::ST_ERR] &&
        sector_count == pq_dco_pkg::RSN_BAD_SUB)
        else $error("reserved subcommand not aborted");
    chk_identify_start: assert property (start_send |=> rd_valid && rd_data == pq_dco_pkg::STRUCT_REV
        && status_reg[pq_dco_pkg::ST_DRQ])
        else $error("identify did not present structure revision");
    chk_identify_full: assert property (phase == pq_dco_pkg::SEND && rd_valid && idx == pq_dco_pkg::WORD_MDMA
        |-> rd_data == FACT_MDMA)
        else $error("identify reported reduced capabilities");
    chk_restore_caps: assert property (do_restore |=> cap_mdma == FACT_MDMA && cap_feat == FACT_FEAT
        && cap_max_lba == FACT_MAXLBA && cmd_done)
        else $error("restore did not bring back full capabilities");
    chk_set_masked: assert property (do_set |=> cap_udma == ($past(rx_udma) & FACT_UDMA)
        && cap_feat == ($past(rx_feat) & FACT_FEAT))
        else $error("set overlay not masked by full capabilities");
    chk_hpa_abort: assert property (phase == pq_dco_pkg::APPLY && rx_sum == 8'h00 && rx_sig_ok && lba_change
        && hpa_established && !max_addr_locked |=> sector_count == pq_dco_pkg::RSN_HPA
        && lba_high == pq_dco_pkg::WORD_LBA0 && lba_mid == pq_dco_pkg::BIT_ZERO
        && $stable(cap_max_lba))
        else $error("protected area change not aborted with code 06h");

    cov_pq_alt: cover property (is_pq && cmd_code == pq_dco_pkg::OP_POWER_QUERY_ALT);
    cov_freeze: cover property (do_freeze);
    cov_identify_end: cover property (phase == pq_dco_pkg::SEND && fin);
    cov_set_applied: cover property (do_set);
endmodule

//--- src/pq_dco_pkg.sv
package pq_dco_pkg;
    localparam logic [7:0]  OP_POWER_QUERY     = 8'hE5;
    localparam logic [7:0]  OP_POWER_QUERY_ALT = 8'h98;
    localparam logic [7:0]  OP_OVERLAY         = 8'hB1;

    localparam logic [7:0]  SUB_RESTORE  = 8'hC0;
    localparam logic [7:0]  SUB_FREEZE   = 8'hC1;
    localparam logic [7:0]  SUB_IDENTIFY = 8'hC2;
    localparam logic [7:0]  SUB_SET      = 8'hC3;

    localparam logic [7:0]  RSN_NONE        = 8'h00;
    localparam logic [7:0]  RSN_FROZEN      = 8'h01;
    localparam logic [7:0]  RSN_MAX_LOCKED  = 8'h05;
    localparam logic [7:0]  RSN_HPA         = 8'h06;
    localparam logic [7:0]  RSN_UNSUPPORTED = 8'h07;
    localparam logic [7:0]  RSN_BAD_SUB     = 8'h08;
    localparam logic [7:0]  RSN_OTHER       = 8'hFF;

    localparam logic [7:0]  SC_SPUN_UP   = 8'hFF;
    localparam logic [7:0]  SC_NOT_READY = 8'h00;

    localparam logic [7:0]  WORD_REV  = 8'h00;
    localparam logic [7:0]  WORD_MDMA = 8'h01;
    localparam logic [7:0]  WORD_UDMA = 8'h02;
    localparam logic [7:0]  WORD_LBA0 = 8'h03;
    localparam logic [7:0]  WORD_LBA1 = 8'h04;
    localparam logic [7:0]  WORD_LBA2 = 8'h05;
    localparam logic [7:0]  WORD_LBA3 = 8'h06;
    localparam logic [7:0]  WORD_FEAT = 8'h07;
    localparam logic [7:0]  WORD_LAST = 8'hFF;
    localparam logic [7:0]  BIT_ZERO  = 8'h00;

    localparam logic [15:0] STRUCT_REV = 16'h0001;
    localparam logic [7:0]  SIGNATURE  = 8'hA5;

    localparam int          ST_BSY  = 7;
    localparam int          ST_RDY  = 6;
    localparam int          ST_DSC  = 4;
    localparam int          ST_DRQ  = 3;
    localparam int          ST_ERR  = 0;
    localparam int          ERR_ABT = 2;
    localparam logic [7:0]  STATUS_READY = 8'h50;
    localparam logic [7:0]  REG_CLEAR    = 8'h00;

    typedef enum logic [1:0] {IDLE, SEND, RECV, APPLY} phase_e;
endpackage

//--- verif/ata_host_model.sv
`timescale 1ns/100ps
module ata_host_model (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        send,
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data,
    output logic             rd_ready,
    output logic             wr_valid,
    output logic      [15:0] wr_data
);
    logic [15:0] rx_img [0:255];
    logic [15:0] tx_img [0:255];
    logic [8:0]  tx_cnt;
    logic [7:0]  rx_cnt;
    logic        tick;

    // slow mode stalls every other cycle so the device must hold its word
    assign rd_ready = !slow || tick;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_cnt <= 8'h00;
        end else if (rd_valid && rd_ready) begin
            rx_img[rx_cnt] <= rd_data;
            rx_cnt         <= rx_cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_cnt   <= 9'h100;
            wr_valid <= 1'b0;
            wr_data  <= 16'h0000;
        end else if (send) begin
            tx_cnt   <= 9'h000;
            wr_valid <= 1'b0;
        end else if (!tx_cnt[8] && rd_ready) begin
            wr_valid <= 1'b1;
            wr_data  <= tx_img[tx_cnt[7:0]];
            tx_cnt   <= tx_cnt + 9'h001;
        end else begin
            // idle bus toggles so a stale word is never mistaken for data
            wr_valid <= 1'b0;
            wr_data  <= ~wr_data;
        end
    end
endmodule

//--- verif/power_query_and_config_overlay_tb_top.sv
`timescale 1ns/100ps
module power_query_and_config_overlay_tb_top;
    localparam logic [15:0] MDMA   = 16'h0007;
    localparam logic [15:0] UDMA   = 16'h003F;
    localparam logic [63:0] MAXLBA = 64'h0000_0000_0012_3456;
    localparam logic [15:0] FEAT   = 16'h008F;
    logic        core_clk = 1'b0, rstn = 1'b0, ata_reset = 1'b0, cmd_wr = 1'b0;
    logic        spin = 1'b0, stby = 1'b0, slp = 1'b0, hpa = 1'b0, slow = 1'b0, send = 1'b0, lock = 1'b0;
    logic [7:0]  cmd_code = 8'h00, features = 8'h00;
    logic        rd_ready, wr_valid, rd_valid, cmd_done, frozen;
    logic [15:0] wr_data, rd_data, cap_mdma, cap_udma, cap_feat;
    logic [7:0]  sector_count, lba_mid, lba_high, error_reg, status_reg;
    logic [63:0] cap_max_lba;
    int          mismatches = 0, compares = 0, cycles = 0;

    power_query_and_config_overlay #(.FACT_MDMA(MDMA), .FACT_UDMA(UDMA), .FACT_MAXLBA(MAXLBA), .FACT_FEAT(FEAT)) dut (
        .core_clk(core_clk), .rstn(rstn), .ata_reset(ata_reset), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .features(features), .spindle_at_speed(spin), .standby_mode(stby), .sleep_mode(slp),
        .hpa_established(hpa), .max_addr_locked(lock), .rd_ready(rd_ready), .wr_valid(wr_valid),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .sector_count(sector_count),
        .lba_mid(lba_mid), .lba_high(lba_high), .error_reg(error_reg), .status_reg(status_reg),
        .cmd_done(cmd_done), .frozen(frozen), .cap_mdma(cap_mdma), .cap_udma(cap_udma),
        .cap_max_lba(cap_max_lba), .cap_feat(cap_feat));
    ata_host_model host (.core_clk(core_clk), .rstn(rstn), .slow(slow), .send(send), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_ready(rd_ready), .wr_valid(wr_valid), .wr_data(wr_data));

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // bounded wait on the completion pulse; the answer registers then stand
    task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input bit snd);
        @(posedge core_clk);
        cmd_wr   <= 1'b1;
        cmd_code <= op;
        features <= ft;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        send   <= snd;
        // an immediate answer stands only until the next edge, so look first
        for (int i = 0; i < 2000; i++) begin
            #1;
            if (cmd_done === 1'b1) break;
            @(posedge core_clk);
            send <= 1'b0;
        end
        send <= 1'b0;
        cmp(cmd_done, 1'b1);
    endtask

    task automatic ans(input logic [7:0] sc, input bit ab);
        cmp(sector_count, sc);
        cmp(error_reg, ab ? 8'h04 : 8'h00);
        cmp(status_reg, ab ? 8'h51 : 8'h50);
    endtask

    task automatic load_overlay(input logic [15:0] w1, input logic [63:0] lba);
        logic [7:0] sum;
        sum = 8'hA5;
        for (int i = 0; i < 255; i++) host.tx_img[i] = 16'h0000;
        host.tx_img[0] = 16'h0001;
        host.tx_img[1] = w1;
        host.tx_img[2] = 16'hFFFF;
        for (int i = 0; i < 4; i++) host.tx_img[3 + i] = lba[16 * i +: 16];
        host.tx_img[7] = FEAT;
        for (int i = 0; i < 255; i++) sum = sum + host.tx_img[i][7:0] + host.tx_img[i][15:8];
        host.tx_img[255] = {8'h00 - sum, 8'hA5};
    endtask

    task automatic query_test();
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            spin <= i[0];
            stby <= i[1];
            slp  <= i[2];
            cmd(i[0] ? 8'h98 : 8'hE5, 8'h00, 1'b0);
            ans((i == 1) ? 8'hFF : 8'h00, 1'b0);
        end
        cmd(8'hB1, 8'hC4, 1'b0);
        ans(8'h08, 1'b1);
    endtask

    task automatic identify_test(input bit s);
        logic [7:0] sum;
        sum  = 8'h00;
        slow <= s;
        cmd(8'hB1, 8'hC2, 1'b0);
        ans(8'h00, 1'b0);
        for (int i = 0; i < 256; i++) sum = sum + host.rx_img[i][7:0] + host.rx_img[i][15:8];
        cmp(host.rx_img[0], 16'h0001);
        cmp(host.rx_img[1], MDMA);
        cmp(host.rx_img[2], UDMA);
        cmp(host.rx_img[3], MAXLBA[15:0]);
        cmp(host.rx_img[7], FEAT);
        cmp(host.rx_img[255][7:0], 8'hA5);
        cmp(sum, 8'h00);
    endtask

    task automatic overlay_test();
        load_overlay(16'h0003, MAXLBA);
        cmd(8'hB1, 8'hC3, 1'b1);
        ans(8'h00, 1'b0);
        cmp(cap_mdma, 16'h0003);
        cmp(cap_udma, UDMA);
        identify_test(1'b0);
        hpa <= 1'b1;
        load_overlay(16'h0001, MAXLBA - 64'h1);
        cmd(8'hB1, 8'hC3, 1'b1);
        ans(8'h06, 1'b1);
        cmp(lba_high, 8'h03);
        cmp(lba_mid, 8'h00);
        cmp(cap_mdma, 16'h0003);
        cmd(8'hB1, 8'hC0, 1'b0);
        ans(8'h00, 1'b0);
        cmp(cap_mdma, MDMA);
        hpa <= 1'b0;
        cmd(8'hB1, 8'hC3, 1'b1);
        ans(8'h00, 1'b0);
        cmp(cap_max_lba, MAXLBA - 64'h1);
        cmp(cap_feat, FEAT);
        hpa <= 1'b1;
        cmd(8'hB1, 8'hC0, 1'b0);
        ans(8'h06, 1'b1);
        hpa  <= 1'b0;
        lock <= 1'b1;
        cmd(8'hB1, 8'hC0, 1'b0);
        ans(8'h05, 1'b1);
        cmp(lba_high, 8'h03);
        lock <= 1'b0;
        cmd(8'hB1, 8'hC0, 1'b0);
        ans(8'h00, 1'b0);
        cmp(cap_max_lba, MAXLBA);
        host.tx_img[255] = host.tx_img[255] ^ 16'h0100;
        cmd(8'hB1, 8'hC3, 1'b1);
        ans(8'hFF, 1'b1);
        cmp(lba_high, 8'hFF);
        cmp(cap_mdma, MDMA);
    endtask

    task automatic freeze_test();
        cmd(8'hB1, 8'hC1, 1'b0);
        ans(8'h00, 1'b0);
        cmp(frozen, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cmd(i[0] ? 8'h98 : 8'hE5, 8'h00, 1'b0);
            cmd(8'hB1, 8'hC0 + i[7:0], 1'b0);
            ans(8'h01, 1'b1);
        end
        @(posedge core_clk);
        ata_reset <= 1'b1;
        @(posedge core_clk);
        ata_reset <= 1'b0;
        cmd(8'hB1, 8'hC2, 1'b0);
        ans(8'h01, 1'b1);
        cmp(frozen, 1'b1);
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        cmp(frozen, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        query_test();
        identify_test(1'b1);
        overlay_test();
        freeze_test();
        close_out();
    end
endmodule
